/* File: include/dsau_defines.svh */
/*
  Address map constants, field positions and steering values for the
  data space access unit.
  Assumes it is included by bare name from the package; the design has no include of its own.
*/
`ifndef DSAU_DEFINES_SVH
`define DSAU_DEFINES_SVH

`define DSAU_SPECIAL_LAST   16'h07ff
`define DSAU_NEAR_LAST      16'h1fff
`define DSAU_PSV_BIT        15
`define DSAU_BYTE_STEP      16'h0001
`define DSAU_WORD_STEP      16'h0002
`define DSAU_NEAR_BITS      13
`define DSAU_RAM_BASE       16'h0800
`define DSAU_RAM_WORDS      1024
`define DSAU_Y_BASE         16'h0c00
`define DSAU_SIGN_BIT       7

`endif

/* File: include/dsau_pkg.sv */
/*
  Types shared by the data space access unit.
  Assumes the defines header is on the include path.
*/
`include "dsau_defines.svh"

package dsau_pkg;

  typedef enum logic [1:0]
  {
    DSAU_MODE_INDIRECT,
    DSAU_MODE_POSTINC,
    DSAU_MODE_DIRECT16,
    DSAU_MODE_NEAR13
  } dsau_mode_t;

  typedef enum logic [1:0]
  {
    DSAU_EXT_NONE,
    DSAU_EXT_SIGN,
    DSAU_EXT_ZERO
  } dsau_ext_t;

  typedef struct packed
  {
    logic        valid;
    logic        write;
    logic        byte_op;
    dsau_mode_t  mode;
    logic [3:0]  ptr_sel;
    logic [15:0] direct_addr;
    logic [15:0] wdata;
  } dsau_xreq_t;

  typedef struct packed
  {
    logic        valid;
    logic [3:0]  ptr_sel;
  } dsau_yreq_t;

endpackage

/* File: src/dsau_access_unit.sv */
/*
  Data space access unit: working registers, X/Y read paths, write path,
  byte steering, pointer update, misalignment trap, extend operations.
  Assumes a core execution unit on CLK issuing at most one X request and
  one Y request per cycle; all inputs are synchronous to CLK.
*/
// Operation
// - Post-increment adds 1 for byte, 2 for word operations.
// - Byte read fetches word, bit 0 picks byte, placed on low lane.
// - Two byte lanes share word decode, separate write strobes.
// - Word access to odd address raises address error trap.
// - Misaligned read completes instruction, then trap taken.
// - Misaligned write executes but memory write is suppressed, then trap.
// - Byte load into working register never occurs; hit_ld is held at 0.
// - Sign-extend 8 to 16 bits; zero-extend clears high byte.
// - Addresses 0x0000 to 0x07FF decode as special register area.
// - Unimplemented special register addresses read zero.
// - Near space to 0x1FFF reached by 13-bit direct field.
// - Whole space reached by 16-bit direct or register pointer.
// - Two address generators fetch two words concurrently.
// - X space has separate read and write buses.
// - Y space gives second read path for dual operand class.
// - All writes use combined X/Y space; boundary is fixed.
// - Effective addresses are 16-bit byte pointers, 64 Kbyte range.
// - Addresses outside implemented memory read zero.
// - Bit 15 set steers X access to program space window; Y reads there return zero.
`timescale 1ns/100ps

module dsau_access_unit
  import dsau_pkg::*;
#(
  parameter int RAM_WORDS = `DSAU_RAM_WORDS
)
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // X request
  input  wire dsau_xreq_t  XREQ,
  // Y request
  input  wire dsau_yreq_t  YREQ,
  // Extend operation on a working register
  input  wire dsau_ext_t   EXT_OP,
  input  wire logic [3:0]  EXT_SEL,
  // Special register area port
  input  wire logic [15:0] SPECIAL_RDATA,
  input  wire logic        SPECIAL_HIT,
  // Program space window port
  input  wire logic [15:0] PSV_RDATA,
  // Results
  output logic [15:0]      X_RDATA,
  output logic             X_RVALID,
  output logic [15:0]      Y_RDATA,
  output logic             Y_RVALID,
  output logic [15:0]      BYTE_POINTER_VALUE,
  output logic             SPECIAL_WE_LO,
  output logic             SPECIAL_WE_HI,
  output logic [15:0]      SPECIAL_ADDR,
  output logic [15:0]      SPECIAL_WDATA,
  output logic             PSV_ACCESS,
  output logic             ADDR_ERR_TRAP
);

  localparam int AW = $clog2(RAM_WORDS);

  // The RAM must fit between its base and the program window.
  if (RAM_WORDS < 2 || RAM_WORDS > 15360)
  begin : g_bad_ram_words
    $error("RAM_WORDS out of range");
  end

  logic [15:0] wreg_reg [16];
  logic [7:0]  ram_lo [RAM_WORDS];
  logic [7:0]  ram_hi [RAM_WORDS];

  logic [15:0] x_ea;
  logic [15:0] y_ea;
  logic        x_mis;
  logic        x_in_ram;
  logic        y_in_ram;
  logic [AW-1:0] x_idx;
  logic [AW-1:0] y_idx;
  logic [15:0] x_word;
  logic [15:0] y_word;
  logic [15:0] x_step;
  logic [15:0] ram_off_x;
  logic [15:0] ram_off_y;

  always_comb
  begin
    case (XREQ.mode)
      DSAU_MODE_NEAR13:   x_ea = {3'h0, XREQ.direct_addr[12:0]};
      DSAU_MODE_DIRECT16: x_ea = XREQ.direct_addr;
      default:            x_ea = wreg_reg[XREQ.ptr_sel];
    endcase
  end

  assign y_ea = wreg_reg[YREQ.ptr_sel];
  assign ram_off_x = x_ea - `DSAU_RAM_BASE;
  assign ram_off_y = y_ea - `DSAU_RAM_BASE;
  assign x_mis = XREQ.valid && !XREQ.byte_op && x_ea[0];
  // implemented range check; bit 15 excluded
  assign x_in_ram = !x_ea[`DSAU_PSV_BIT] && x_ea >= `DSAU_RAM_BASE
                    && ram_off_x[15:1] < 15'(RAM_WORDS);
  assign y_in_ram = !y_ea[`DSAU_PSV_BIT] && y_ea >= `DSAU_RAM_BASE
                    && ram_off_y[15:1] < 15'(RAM_WORDS);
  assign x_idx = ram_off_x[AW:1];
  assign y_idx = ram_off_y[AW:1];

  // shared word decode for both lanes
  always_comb
  begin
    x_word = 16'h0000;
    if (x_ea[`DSAU_PSV_BIT])
      x_word = PSV_RDATA;
    // special register decode; unused reads zero
    else if (x_ea <= `DSAU_SPECIAL_LAST)
      x_word = SPECIAL_HIT ? SPECIAL_RDATA : 16'h0000;
    else if (x_in_ram)
      x_word = {ram_hi[x_idx], ram_lo[x_idx]};
  end

  always_comb
  begin
    y_word = 16'h0000;
    if (y_in_ram)
      y_word = {ram_hi[y_idx], ram_lo[y_idx]};
  end

  assign x_step = XREQ.byte_op ? `DSAU_BYTE_STEP : `DSAU_WORD_STEP;

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      X_RDATA  <= 16'h0000;
      X_RVALID <= 1'b0;
    end
    else
    begin
      X_RVALID <= XREQ.valid && !XREQ.write;
      if (XREQ.byte_op)
        X_RDATA <= {8'h00, x_ea[0] ? x_word[15:8] : x_word[7:0]};
      else
        X_RDATA <= x_word;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      Y_RDATA  <= 16'h0000;
      Y_RVALID <= 1'b0;
    end
    else
    begin
      Y_RVALID <= YREQ.valid;
      Y_RDATA  <= y_word;
    end
  end

  // read finishes; trap after suppressed write
  always_ff @(posedge CLK)
  begin
    if (SRST)
      ADDR_ERR_TRAP <= 1'b0;
    else
      ADDR_ERR_TRAP <= x_mis;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      BYTE_POINTER_VALUE <= 16'h0000;
    else if (XREQ.valid)
      BYTE_POINTER_VALUE <= x_ea;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      PSV_ACCESS <= 1'b0;
    else
      PSV_ACCESS <= XREQ.valid && x_ea[`DSAU_PSV_BIT];
  end

  // writes use combined space; X write path only
  always_ff @(posedge CLK)
  begin
    if (XREQ.valid && XREQ.write && !x_mis && x_in_ram)
    begin
      if (!XREQ.byte_op || !x_ea[0])
        ram_lo[x_idx] <= XREQ.wdata[7:0];
      if (!XREQ.byte_op)
        ram_hi[x_idx] <= XREQ.wdata[15:8];
      else if (x_ea[0])
        ram_hi[x_idx] <= XREQ.wdata[7:0];
    end
  end

  // special register strobes suppressed when misaligned
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      SPECIAL_WE_LO <= 1'b0;
      SPECIAL_WE_HI <= 1'b0;
      SPECIAL_ADDR  <= 16'h0000;
      SPECIAL_WDATA <= 16'h0000;
    end
    else
    begin
      SPECIAL_WE_LO <= XREQ.valid && XREQ.write && !x_mis
                       && x_ea <= `DSAU_SPECIAL_LAST
                       && (!XREQ.byte_op || !x_ea[0]);
      SPECIAL_WE_HI <= XREQ.valid && XREQ.write && !x_mis
                       && x_ea <= `DSAU_SPECIAL_LAST
                       && (!XREQ.byte_op || x_ea[0]);
      SPECIAL_ADDR  <= {x_ea[15:1], 1'b0};
      SPECIAL_WDATA <= XREQ.byte_op ? {2{XREQ.wdata[7:0]}} : XREQ.wdata;
    end
  end

  // Working registers: one generate entry per register.
  for (genvar g = 0; g < 16; g++)
  begin : g_wreg
    logic hit_ld;
    logic hit_inc;
    logic hit_ext;
    assign hit_ld  = XREQ.valid && XREQ.write && XREQ.mode
                     == DSAU_MODE_INDIRECT && 1'b0;
    assign hit_inc = XREQ.valid && XREQ.mode == DSAU_MODE_POSTINC
                     && XREQ.ptr_sel == 4'(g);
    assign hit_ext = EXT_OP != DSAU_EXT_NONE && EXT_SEL == 4'(g);
    always_ff @(posedge CLK)
    begin
      if (SRST)
        wreg_reg[g] <= 16'h0000;
      else if (hit_ext && EXT_OP == DSAU_EXT_SIGN)
        wreg_reg[g] <= {{8{wreg_reg[g][`DSAU_SIGN_BIT]}},
                        wreg_reg[g][7:0]};
      else if (hit_ext)
        wreg_reg[g] <= {8'h00, wreg_reg[g][7:0]};
      else if (hit_inc)
        wreg_reg[g] <= wreg_reg[g] + x_step;
      else if (hit_ld && XREQ.byte_op)
        wreg_reg[g] <= {wreg_reg[g][15:8], XREQ.wdata[7:0]};
    end
  end

  a_trap_odd_word: assert property (@(posedge CLK) disable iff (SRST)
    XREQ.valid && !XREQ.byte_op && x_ea[0] |=> ADDR_ERR_TRAP)
    else $error("odd word access without trap");

  a_no_mis_write: assert property (@(posedge CLK) disable iff (SRST)
    x_mis && XREQ.write |=> !SPECIAL_WE_LO && !SPECIAL_WE_HI)
    else $error("misaligned write reached memory");

  a_mis_read_done: assert property (@(posedge CLK) disable iff (SRST)
    x_mis && !XREQ.write |=> X_RVALID && ADDR_ERR_TRAP)
    else $error("misaligned read not completed");

  a_byte_low_lane: assert property (@(posedge CLK) disable iff (SRST)
    XREQ.valid && !XREQ.write && XREQ.byte_op |=> X_RDATA[15:8] == 8'h00)
    else $error("byte read not on low lane");

  a_byte_one_lane: assert property (@(posedge CLK) disable iff (SRST)
    XREQ.valid && XREQ.write && XREQ.byte_op |=>
    !(SPECIAL_WE_LO && SPECIAL_WE_HI))
    else $error("byte write hit both lanes");

  a_post_inc_step: assert property (@(posedge CLK) disable iff (SRST)
    XREQ.valid && XREQ.mode == DSAU_MODE_POSTINC && EXT_OP == DSAU_EXT_NONE
    |=> wreg_reg[$past(XREQ.ptr_sel)] ==
        $past(wreg_reg[XREQ.ptr_sel]) + $past(x_step))
    else $error("post increment step wrong");

  a_psv_steer: assert property (@(posedge CLK) disable iff (SRST)
    XREQ.valid && x_ea[15] |=> PSV_ACCESS)
    else $error("window access not flagged");

  a_y_path: assert property (@(posedge CLK) disable iff (SRST)
    YREQ.valid |=> Y_RVALID)
    else $error("Y read missing");

endmodule // dsau_access_unit

/* File: verif/dsau_far_model.sv */
/*
  Far-side model: special register area and program window.
  Assumes the bench uses direct address modes when it reads them.
*/
`timescale 1ns/100ps
module dsau_far_model
  import dsau_pkg::*;
(
  // Request seen
  input  wire dsau_xreq_t  XREQ,
  // Answers
  output logic [15:0]      SPECIAL_RDATA,
  output logic             SPECIAL_HIT,
  output logic [15:0]      PSV_RDATA
);
  logic [15:0] addr;

  assign addr = (XREQ.mode == DSAU_MODE_NEAR13) ?
                {3'h0, XREQ.direct_addr[12:0]} : XREQ.direct_addr;
  // Only the low 256 bytes hold registers; elsewhere the lines carry the inverted address.
  assign SPECIAL_HIT   = addr < 16'h0100;
  assign SPECIAL_RDATA = SPECIAL_HIT ? {addr[7:0], 8'ha5} : ~addr;
  assign PSV_RDATA     = addr ^ 16'h3c3c;
endmodule // dsau_far_model

/* File: verif/data_space_access_unit_tb.sv */
/*
  Self-checking bench for the data space access unit.
  Assumes the far-side model stands in for registers and window.
*/
`timescale 1ns/100ps
module data_space_access_unit_tb
  import dsau_pkg::*;
;
  localparam int         RW  = 16;
  localparam dsau_mode_t D16 = DSAU_MODE_DIRECT16;
  localparam dsau_mode_t PI  = DSAU_MODE_POSTINC;
  localparam dsau_mode_t IND = DSAU_MODE_INDIRECT;

  logic        clk;
  logic        srst;
  dsau_xreq_t  xreq;
  dsau_yreq_t  yreq;
  dsau_ext_t   ext_op;
  logic [3:0]  ext_sel;
  logic [15:0] sp_rdata, psv_rdata, x_rdata, y_rdata, bpv, sp_addr, sp_wd;
  logic        sp_hit, x_rv, y_rv, we_lo, we_hi, psv, trap;
  logic [4:0]  fl;
  int          err_total;
  int          num_checks;

  dsau_access_unit #(.RAM_WORDS(RW)) dsau_access_unit_i (
    .CLK(clk), .SRST(srst), .XREQ(xreq), .YREQ(yreq),
    .EXT_OP(ext_op), .EXT_SEL(ext_sel),
    .SPECIAL_RDATA(sp_rdata), .SPECIAL_HIT(sp_hit), .PSV_RDATA(psv_rdata),
    .X_RDATA(x_rdata), .X_RVALID(x_rv), .Y_RDATA(y_rdata),
    .Y_RVALID(y_rv), .BYTE_POINTER_VALUE(bpv), .SPECIAL_WE_LO(we_lo),
    .SPECIAL_WE_HI(we_hi), .SPECIAL_ADDR(sp_addr),
    .SPECIAL_WDATA(sp_wd), .PSV_ACCESS(psv), .ADDR_ERR_TRAP(trap));

  dsau_far_model dsau_far_model_i (
    .XREQ(xreq), .SPECIAL_RDATA(sp_rdata), .SPECIAL_HIT(sp_hit),
    .PSV_RDATA(psv_rdata));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s %h/%h", $time, what, got, exp);
    end
  endtask

  // Flags are {read valid, trap, window, strobe high, strobe low}.
  task automatic chkf(input logic [4:0] got, exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s %b/%b", $time, what, got, exp);
    end
  endtask

  // One X access; results are sampled just after the answering edge.
  task automatic xop(input logic wr, bo, input dsau_mode_t md,
                     input logic [3:0] ps, input logic [15:0] a, d);
    @(posedge clk);
    xreq <= '{1'b1, wr, bo, md, ps, a, d};
    @(posedge clk);
    xreq.valid <= 1'b0;
    #1;
    fl = {x_rv, trap, psv, we_hi, we_lo};
  endtask

  task automatic t_lanes();
    xop(1, 0, D16, 0, 16'h0800, 16'h1234);
    xop(1, 1, D16, 0, 16'h0801, 16'habab);
    xop(0, 0, D16, 0, 16'h0800, 0);
    chk(x_rdata, 16'hab34, "lane write");
    xop(0, 1, D16, 0, 16'h0801, 0);
    chk(x_rdata, 16'h00ab, "byte read high");
    xop(0, 1, D16, 0, 16'h0800, 0);
    chk(x_rdata, 16'h0034, "byte read low");
  endtask

  task automatic t_misalign();
    xop(1, 0, D16, 0, 16'h0802, 16'hbeef);
    xop(1, 0, D16, 0, 16'h0803, 16'h1111);
    chkf(fl, 5'b01000, "odd write");
    xop(0, 0, D16, 0, 16'h0803, 0);
    chkf(fl, 5'b11000, "odd read");
    xop(0, 0, D16, 0, 16'h0802, 0);
    chk(x_rdata, 16'hbeef, "write kept out");
  endtask

  task automatic t_special();
    xop(0, 0, D16, 0, 16'h0010, 0);
    chk(x_rdata, 16'h10a5, "register read");
    xop(0, 0, D16, 0, 16'h0200, 0);
    chk(x_rdata, 16'h0000, "empty register");
    xop(1, 1, D16, 0, 16'h0011, 16'h005a);
    chkf(fl, 5'b00010, "byte strobe");
    chk(sp_wd, 16'h5a5a, "byte on both lanes");
    chk(sp_addr, 16'h0010, "register addr");
    xop(1, 0, D16, 0, 16'h0010, 16'h5a5a);
    chkf(fl, 5'b00011, "word strobes");
  endtask

  task automatic t_space();
    xop(1, 0, D16, 0, 16'h0810, 16'h1234);
    xop(0, 0, DSAU_MODE_NEAR13, 0, 16'he810, 0);
    chk(x_rdata, 16'h1234, "near read");
    chk(bpv, 16'h0810, "near pointer");
    xop(0, 0, D16, 0, 16'h0800 + 16'(RW * 2), 0);
    chk(x_rdata, 16'h0000, "outside ram");
    xop(0, 0, D16, 0, 16'h8006, 0);
    chkf(fl, 5'b10100, "window flags");
    chk(x_rdata, 16'h8006 ^ 16'h3c3c, "window data");
  endtask

  task automatic t_ptr();
    xop(0, 1, PI, 4'h1, 0, 0);
    xop(0, 1, PI, 4'h1, 0, 0);
    chk(bpv, 16'h0001, "byte step");
    xop(0, 0, PI, 4'h3, 0, 0);
    xop(0, 0, PI, 4'h3, 0, 0);
    chk(bpv, 16'h0002, "word step");
    yreq <= '{1'b1, 4'h3};
    xop(0, 0, IND, 4'h3, 0, 0);
    yreq <= '0;
    chk(bpv, 16'h0004, "indirect");
    chkf({y_rv, fl[4], 3'h0}, 5'b11000, "dual read");
    chk(y_rdata, 16'h0000, "Y outside ram");
  endtask

  task automatic t_ext();
    repeat (128) xop(0, 1, PI, 4'h2, 0, 0);
    @(posedge clk);
    ext_op  <= DSAU_EXT_SIGN;
    ext_sel <= 4'h2;
    @(posedge clk);
    ext_op <= DSAU_EXT_NONE;
    xop(0, 0, IND, 4'h2, 0, 0);
    chk(bpv, 16'hff80, "sign extend");
    @(posedge clk);
    ext_op <= DSAU_EXT_ZERO;
    @(posedge clk);
    ext_op <= DSAU_EXT_NONE;
    xop(0, 0, IND, 4'h2, 0, 0);
    chk(bpv, 16'h0080, "zero fill");
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    #(2000 * 100);
    err_total++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    report_and_stop();
  end

  initial
  begin
    srst       = 1'b1;
    xreq       = '0;
    yreq       = '0;
    ext_op     = DSAU_EXT_NONE;
    ext_sel    = 4'h0;
    err_total  = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_lanes();
    t_misalign();
    t_special();
    t_space();
    t_ptr();
    t_ext();
    report_and_stop();
  end
endmodule // data_space_access_unit_tb
